// *** logic/drive_cmd_pkg.sv ***
/*
  Shared constants for the drive command source combiner: register
  offsets, field positions, reset values, protocol and selector codes,
  and the baud-rate table.
  Assumes a 32-bit APB register bus and a 16-bit serial control word.
*/
package drive_cmd_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_STATION = 8'h00;
  localparam logic [7:0] OFS_BAUD = 8'h04;
  localparam logic [7:0] OFS_SOURCE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  // Protocol codes held in the station register.
  localparam logic [1:0] PROTO_NATIVE = 2'h0;
  localparam logic [1:0] PROTO_BLDG = 2'h1;
  localparam logic [1:0] PROTO_MODBUS = 2'h3;

  // Station address limits per protocol.
  localparam logic [7:0] ADDR_NATIVE_MIN = 8'h00;
  localparam logic [7:0] ADDR_NATIVE_MAX = 8'hF7;
  localparam logic [7:0] ADDR_BLDG_MIN = 8'h01;
  localparam logic [7:0] ADDR_BLDG_MAX = 8'hFF;
  localparam logic [7:0] ADDR_MODBUS_MIN = 8'h01;
  localparam logic [7:0] ADDR_MODBUS_MAX = 8'hF7;
  localparam logic [7:0] ADDR_RESET = 8'h01;

  // Baud codes and their bit rates.
  localparam logic [2:0] BAUD_CODE_MAX = 3'h5;
  localparam logic [2:0] BAUD_RESET = 3'h5;
  localparam logic [13:0] BPS_300 = 14'h012C;
  localparam logic [13:0] BPS_600 = 14'h0258;
  localparam logic [13:0] BPS_1200 = 14'h04B0;
  localparam logic [13:0] BPS_2400 = 14'h0960;
  localparam logic [13:0] BPS_4800 = 14'h12C0;
  localparam logic [13:0] BPS_9600 = 14'h2580;

  // Source selector codes.
  localparam logic [1:0] SRC_LOCAL = 2'h0;
  localparam logic [1:0] SRC_SERIAL = 2'h1;
  localparam logic [1:0] SRC_EITHER = 2'h2;
  localparam logic [1:0] SRC_BOTH = 2'h3;
  localparam logic [1:0] SRC_RESET = 2'h3;

  // Field positions.
  localparam int F_PROTO_LO = 0;
  localparam int F_ADDR_LO = 8;
  localparam int F_SRC_COAST = 0;
  localparam int F_SRC_QSTOP = 2;
  localparam int F_SRC_DC = 4;
  localparam int F_ST_COAST = 16;
  localparam int F_ST_QSTOP = 17;
  localparam int F_ST_DC = 18;
  localparam int F_ST_REJECT = 19;

  // Control word bits.
  localparam int CW_DC = 2;
  localparam int CW_COAST = 3;
  localparam int CW_QSTOP = 4;
  localparam int CW_VALID = 10;

  localparam logic [15:0] CW_RESET = 16'hFFFF;

endpackage

// *** logic/drive_command_source_combiner.sv ***
/*
  Drive command source combiner: station address and baud settings
  held for the serial network, plus the merge of local stop inputs
  with serial control-word bits for coasting, quick stop and DC brake.
  Assumes software reaches the settings over APB from the local control
  unit, the serial frame logic delivers decoded control words and
  setting-change attempts on pclk, and stop inputs are raw pins.
*/
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps

// Functional notes
// R01 - Native protocol accepts station addresses 0 to 247, default 1.
// R02 - Building-automation protocol accepts station addresses 1 to 255.
// R03 - Modbus RTU accepts station addresses 1 to 247.
// R04 - Integrator gives each drive on the network its own address.
// R05 - Station address changes from the serial link are rejected.
// R06 - Baud codes 0..5 mean 300 to 9600 bit/s, default code 5.
// R07 - Baud changes from the serial link are rejected.
// R08 - Drive baud setting and master rate must match.
// R09 - Each stop command has a two-bit source selector, default 3.
// R10 - Serial mode lets only the control-word bit act.
// R11 - Coasting input and control bit 3 are active low.
// R12 - Run allowed: 0 local, 1 serial, 2 either high, 3 both high.
// R13 - Quick-stop input and control bit 4 are active low.
// R14 - Quick stop ends with the same four-way merge.
// R15 - DC brake has its own four-way selector, default 3.
// R16 - DC brake input and control bit 2 are active low, same merge.
// R17 - Serial merge input is the latest valid control word bit.
module drive_command_source_combiner
  import drive_cmd_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link side, on pclk.
  input wire logic cw_strobe,
  input wire logic [15:0] cw_word,
  input wire logic ser_setting_wr,
  // Local stop inputs from pins, active low.
  input wire logic coast_pin_n,
  input wire logic qstop_pin_n,
  input wire logic dcbrake_pin_n,
  // Settings and commands out.
  output logic [1:0] protocol,
  output logic [7:0] station_addr,
  output logic [2:0] baud_code,
  output logic [13:0] baud_bps,
  output logic coast_req_n,
  output logic qstop_req_n,
  output logic dcbrake_req_n,
  output logic ser_reject
);

  // Range check of a station address against a protocol code.
  function automatic logic addr_ok(input logic [1:0] proto, input logic [7:0] addr);
    logic ok;
    ok = 1'b0;
    unique case (proto)
      PROTO_NATIVE: ok = (addr >= ADDR_NATIVE_MIN) && (addr <= ADDR_NATIVE_MAX); // R01
      PROTO_BLDG: ok = (addr >= ADDR_BLDG_MIN) && (addr <= ADDR_BLDG_MAX); // R02
      PROTO_MODBUS: ok = (addr >= ADDR_MODBUS_MIN) && (addr <= ADDR_MODBUS_MAX); // R03
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Baud code to bit rate; out-of-range codes never get stored.
  function automatic logic [13:0] baud_decode(input logic [2:0] code);
    logic [13:0] bps;
    bps = BPS_9600;
    unique case (code)
      3'h0: bps = BPS_300; // R06
      3'h1: bps = BPS_600;
      3'h2: bps = BPS_1200;
      3'h3: bps = BPS_2400;
      3'h4: bps = BPS_4800;
      default: bps = BPS_9600;
    endcase
    return bps;
  endfunction

  // Four-way merge of active-low local and serial levels; 1 means release.
  // The either/both naming follows the bit sense: either level high or both levels high releases.
  function automatic logic merge(input logic [1:0] sel, input logic loc, input logic ser);
    logic run;
    run = 1'b0;
    unique case (sel)
      SRC_LOCAL: run = loc;
      SRC_SERIAL: run = ser; // R10
      SRC_EITHER: run = loc | ser;
      SRC_BOTH: run = loc & ser;
    endcase
    return run;
  endfunction

  logic [1:0] protocol_q, protocol_d;
  logic [7:0] station_addr_q, station_addr_d;
  logic [2:0] baud_code_q, baud_code_d;
  logic [13:0] baud_bps_q, baud_bps_d;
  logic [1:0] src_coast_q, src_coast_d;
  logic [1:0] src_qstop_q, src_qstop_d;
  logic [1:0] src_dc_q, src_dc_d;
  logic reject_seen_q, reject_seen_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [15:0] cw_q, cw_d;
  logic ser_reject_q, ser_reject_d;
  logic [2:0] pin_meta_q, pin_sync_q;
  logic coast_req_n_q, coast_req_n_d;
  logic qstop_req_n_q, qstop_req_n_d;
  logic dcbrake_req_n_q, dcbrake_req_n_d;
  logic acc_go, wr_go;
  logic [31:0] rd_word;
  logic wr_bad;
  logic addr_bad;
  logic coast_ref;

  // An access completes one cycle after the access phase starts.
  assign acc_go = psel & penable & pready_q;
  assign wr_go = acc_go & pwrite;

  // Read mux and write legality for the current address.
  always_comb
  begin
    rd_word = '0;
    wr_bad = 1'b0;
    addr_bad = 1'b0;
    unique case (paddr)
      OFS_STATION:
      begin
        rd_word[F_PROTO_LO +: 2] = protocol_q;
        rd_word[F_ADDR_LO +: 8] = station_addr_q;
        wr_bad = !addr_ok(pwdata[F_PROTO_LO +: 2], pwdata[F_ADDR_LO +: 8]);
      end
      OFS_BAUD:
      begin
        rd_word[2:0] = baud_code_q;
        wr_bad = (pwdata[2:0] > BAUD_CODE_MAX);
      end
      OFS_SOURCE:
      begin
        rd_word[F_SRC_COAST +: 2] = src_coast_q;
        rd_word[F_SRC_QSTOP +: 2] = src_qstop_q;
        rd_word[F_SRC_DC +: 2] = src_dc_q;
      end
      OFS_STATUS:
      begin
        rd_word[15:0] = cw_q;
        rd_word[F_ST_COAST] = coast_req_n_q;
        rd_word[F_ST_QSTOP] = qstop_req_n_q;
        rd_word[F_ST_DC] = dcbrake_req_n_q;
        rd_word[F_ST_REJECT] = reject_seen_q;
      end
      default:
      begin
        wr_bad = 1'b1;
        addr_bad = 1'b1;
      end
    endcase
  end

  // APB handshake and register next values. Illegal writes leave state
  // untouched and answer with pslverr, so software sees the refusal.
  always_comb
  begin
    pready_d = psel & penable & ~pready_q;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    protocol_d = protocol_q;
    station_addr_d = station_addr_q;
    baud_code_d = baud_code_q;
    src_coast_d = src_coast_q;
    src_qstop_d = src_qstop_q;
    src_dc_d = src_dc_q;
    reject_seen_d = reject_seen_q;
    if (psel & penable & ~pready_q)
    begin
      prdata_d = pwrite ? '0 : rd_word;
      pslverr_d = pwrite ? wr_bad : addr_bad;
    end
    if (wr_go && !wr_bad)
    begin
      unique case (paddr)
        OFS_STATION:
        begin
          protocol_d = pwdata[F_PROTO_LO +: 2]; // R01 R02 R03
          station_addr_d = pwdata[F_ADDR_LO +: 8];
        end
        OFS_BAUD: baud_code_d = pwdata[2:0]; // R06 R08
        OFS_SOURCE:
        begin
          src_coast_d = pwdata[F_SRC_COAST +: 2]; // R09
          src_qstop_d = pwdata[F_SRC_QSTOP +: 2];
          src_dc_d = pwdata[F_SRC_DC +: 2]; // R15
        end
        OFS_STATUS: if (pwdata[F_ST_REJECT]) reject_seen_d = 1'b0;
        default: reject_seen_d = reject_seen_q;
      endcase
    end
    // A fresh refusal wins over a clear in the same cycle.
    if (ser_setting_wr)
      reject_seen_d = 1'b1; // R05 R07
    baud_bps_d = baud_decode(baud_code_d); // R06
  end

  // Serial side: refuse address and baud changes, keep last valid word.
  always_comb
  begin
    ser_reject_d = ser_setting_wr; // R05 R07
    cw_d = cw_q;
    if (cw_strobe && cw_word[CW_VALID])
      cw_d = cw_word; // R17
  end

  // Merge the synchronised pins with the held control word bits.
  always_comb
  begin
    coast_req_n_d = merge(src_coast_q, pin_sync_q[0], cw_q[CW_COAST]); // R11 R12
    qstop_req_n_d = merge(src_qstop_q, pin_sync_q[1], cw_q[CW_QSTOP]); // R13 R14
    dcbrake_req_n_d = merge(src_dc_q, pin_sync_q[2], cw_q[CW_DC]); // R16
  end

  // Coast reference built from the selector bits directly, so the merge
  // function is not the only judge of its own result.
  always_comb
  begin
    coast_ref = pin_sync_q[0] & cw_q[CW_COAST];
    if (src_coast_q == SRC_LOCAL)
      coast_ref = pin_sync_q[0];
    else if (src_coast_q == SRC_SERIAL)
      coast_ref = cw_q[CW_COAST];
    else if (src_coast_q == SRC_EITHER)
      coast_ref = pin_sync_q[0] | cw_q[CW_COAST];
  end

  // All state registers. Pins pass two flops before the merge reads them.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      protocol_q <= PROTO_NATIVE;
      station_addr_q <= ADDR_RESET; // R01
      baud_code_q <= BAUD_RESET; // R06
      baud_bps_q <= BPS_9600;
      src_coast_q <= SRC_RESET; // R09
      src_qstop_q <= SRC_RESET;
      src_dc_q <= SRC_RESET; // R15
      reject_seen_q <= 1'b0;
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      cw_q <= CW_RESET;
      ser_reject_q <= 1'b0;
      pin_meta_q <= '1;
      pin_sync_q <= '1;
      coast_req_n_q <= 1'b1;
      qstop_req_n_q <= 1'b1;
      dcbrake_req_n_q <= 1'b1;
    end
    else
    begin
      protocol_q <= protocol_d;
      station_addr_q <= station_addr_d;
      baud_code_q <= baud_code_d;
      baud_bps_q <= baud_bps_d;
      src_coast_q <= src_coast_d;
      src_qstop_q <= src_qstop_d;
      src_dc_q <= src_dc_d;
      reject_seen_q <= reject_seen_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      cw_q <= cw_d;
      ser_reject_q <= ser_reject_d;
      pin_meta_q <= {dcbrake_pin_n, qstop_pin_n, coast_pin_n};
      pin_sync_q <= pin_meta_q;
      coast_req_n_q <= coast_req_n_d;
      qstop_req_n_q <= qstop_req_n_d;
      dcbrake_req_n_q <= dcbrake_req_n_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign protocol = protocol_q;
  assign station_addr = station_addr_q;
  assign baud_code = baud_code_q;
  assign baud_bps = baud_bps_q;
  assign coast_req_n = coast_req_n_q;
  assign qstop_req_n = qstop_req_n_q;
  assign dcbrake_req_n = dcbrake_req_n_q;
  assign ser_reject = ser_reject_q;

  // Checks on the stored settings and the merged commands.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_ser_attempt;
    ser_setting_wr;
  endsequence

  sequence s_refused;
    ser_reject_q && $stable(station_addr_q) && $stable(baud_code_q);
  endsequence

  a_addr_in_range: assert property (addr_ok(protocol_q, station_addr_q)) // R01
    else $error("station address outside protocol range");
  a_bldg_addr_low: assert property (protocol_q == PROTO_BLDG |-> station_addr_q != 8'h00) // R02
    else $error("zero address stored under building protocol");
  a_modbus_addr: assert property (protocol_q == PROTO_MODBUS |-> station_addr_q <= ADDR_MODBUS_MAX) // R03
    else $error("modbus address above limit");
  a_serial_refused: assert property ((s_ser_attempt and !wr_go) |=> s_refused) // R05
    else $error("serial setting attempt not refused");
  a_baud_stays: assert property (!wr_go |=> $stable(baud_code_q)) // R07
    else $error("baud code changed without local write");
  a_baud_decode: assert property (##1 baud_bps_q == baud_decode(baud_code_q)) // R06
    else $error("baud rate does not match code");
  a_serial_mode: assert property (src_coast_q == SRC_SERIAL && $stable(src_coast_q)
    |=> coast_req_n_q == $past(cw_q[CW_COAST])) // R10
    else $error("serial mode coast not from control word");
  a_coast_merge: assert property (##1 coast_req_n_q == $past(coast_ref)) // R12
    else $error("coast merge wrong");
  a_qstop_both: assert property (src_qstop_q == SRC_BOTH && !pin_sync_q[1]
    |=> !qstop_req_n_q) // R14
    else $error("quick stop released with local input low");
  a_dc_either: assert property (src_dc_q == SRC_EITHER && cw_q[CW_DC] && pin_sync_q[2]
    |=> dcbrake_req_n_q) // R16
    else $error("dc brake held with both sources high");
  a_cw_hold: assert property (cw_strobe && !cw_word[CW_VALID] |=> $stable(cw_q)) // R17
    else $error("invalid control word taken");
  a_apb_wait: assert property (psel && penable && !pready_q |=> pready_q ##1 !pready_q)
    else $error("apb answer timing wrong");
  a_reject_set: assert property (ser_setting_wr |=> reject_seen_q) // R05
    else $error("serial attempt not recorded");
  a_dc_local: assert property (src_dc_q == SRC_LOCAL
    |=> dcbrake_req_n_q == $past(pin_sync_q[2])) // R15
    else $error("dc brake local mode not from pin");

endmodule

// *** test/serial_master_model.sv ***
/*
  Behavioural serial bus master: hands decoded control words and
  serial attempts to change settings to the combiner on pclk.
  Assumes the bench calls its tasks from a single process.
*/
`timescale 1ns/1ps
module serial_master_model (
  // Clock.
  input wire logic pclk,
  // Decoded link traffic.
  output logic cw_strobe,
  output logic [15:0] cw_word,
  output logic ser_setting_wr
);
  // The master's own address and rate; the address must differ from any drive, the rate must match it.
  localparam logic [7:0] own_station = 8'h00;
  localparam logic [2:0] link_baud = 3'h5;

  // Lines idle quietly; a released word shows its inverse so stale data is never reused.
  initial
  begin
    cw_strobe = 1'b0;
    cw_word = 16'hFFFF;
    ser_setting_wr = 1'b0;
  end

  // One decoded word, one cycle wide.
  task automatic send(input logic [15:0] w);
    @(posedge pclk);
    cw_strobe <= 1'b1;
    cw_word <= w;
    @(posedge pclk);
    cw_strobe <= 1'b0;
    cw_word <= ~w;
  endtask

  // One attempt to change address or baud over the link.
  task automatic poke();
    @(posedge pclk);
    ser_setting_wr <= 1'b1;
    @(posedge pclk);
    ser_setting_wr <= 1'b0;
  endtask
endmodule

// *** test/drive_command_source_combiner_test.sv ***
/*
  Self-checking bench for the command source combiner: APB register
  accesses, serial attempts and merged stop outputs.
  Assumes the serial master model beside it drives the link side.
*/
`timescale 1ns/1ps
module drive_command_source_combiner_test;
  import drive_cmd_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, cw_strobe, ser_setting_wr, ser_reject;
  logic [15:0] cw_word;
  logic coast_pin_n = 1'b1;
  logic qstop_pin_n = 1'b1;
  logic dcbrake_pin_n = 1'b1;
  logic [1:0] protocol, sel;
  logic [7:0] station_addr;
  logic [2:0] baud_code;
  logic [13:0] baud_bps;
  logic coast_req_n, qstop_req_n, dcbrake_req_n;
  logic [13:0] bps [6] = '{BPS_300, BPS_600, BPS_1200, BPS_2400, BPS_4800, BPS_9600};
  // Each entry: refused, protocol, address.
  logic [10:0] tbl [10] = '{11'h000, 11'h0F7, 11'h4F8, 11'h500, 11'h1FF,
                            11'h700, 11'h3F7, 11'h7F8, 11'h605, 11'h301};
  logic [10:0] last;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;

  // Clock at 40 MHz.
  always #12.5 pclk = ~pclk;

  drive_command_source_combiner i_drive_command_source_combiner (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cw_strobe(cw_strobe),
    .cw_word(cw_word), .ser_setting_wr(ser_setting_wr), .coast_pin_n(coast_pin_n),
    .qstop_pin_n(qstop_pin_n), .dcbrake_pin_n(dcbrake_pin_n), .protocol(protocol),
    .station_addr(station_addr), .baud_code(baud_code), .baud_bps(baud_bps),
    .coast_req_n(coast_req_n), .qstop_req_n(qstop_req_n), .dcbrake_req_n(dcbrake_req_n),
    .ser_reject(ser_reject));
  serial_master_model i_serial_master_model (.pclk(pclk), .cw_strobe(cw_strobe),
    .cw_word(cw_word), .ser_setting_wr(ser_setting_wr));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Cuts a hang short; the whole run needs a few hundred cycles.
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; read data and error are taken at the edge that sees pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits as long as the slave needs; only the bench timeout ends a hang.
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic merge(input logic [1:0] s, input logic p, input logic q);
    case (s)
      SRC_LOCAL: return p;
      SRC_SERIAL: return q;
      SRC_EITHER: return p | q;
      default: return p & q;
    endcase
  endfunction

  // Main sequence.
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk({coast_req_n, qstop_req_n, dcbrake_req_n, ser_reject}, 4'b1110);
    apb(1'b0, OFS_STATION, 0);
    chk(rd, 32'h0000_0100);
    apb(1'b0, OFS_SOURCE, 0);
    chk(rd[5:0], 6'h3F);
    chk(baud_bps, BPS_9600);
    apb(1'b0, 8'h10, 0);
    chk(er, 1);
    chk(rd, 32'h0000_0000);
    last = 11'h001;
    for (int i = 0; i < 10; i++)
    begin
      apb(1'b1, OFS_STATION, {16'h0, tbl[i][7:0], 6'h0, tbl[i][9:8]});
      chk(er, tbl[i][10]);
      if (!tbl[i][10])
        last = tbl[i];
      apb(1'b0, OFS_STATION, 0);
      chk({rd[15:8], rd[1:0]}, {last[7:0], last[9:8]});
      chk({station_addr, protocol}, {last[7:0], last[9:8]});
    end
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b1, OFS_BAUD, i);
      chk(er, i == 6);
      apb(1'b0, OFS_BAUD, 0);
      chk(rd[2:0], (i == 6) ? 3'h5 : 3'(i));
      chk(baud_bps, bps[(i == 6) ? 5 : i]);
    end
    i_serial_master_model.poke();
    #1;
    chk(ser_reject, 1);
    @(posedge pclk);
    #1;
    chk(ser_reject, 0);
    apb(1'b0, OFS_STATUS, 0);
    chk(rd[19], 1);
    chk({station_addr, baud_code}, {last[7:0], 3'h5});
    chk(baud_code, i_serial_master_model.link_baud);
    apb(1'b1, OFS_STATUS, 32'h0008_0000);
    chk(er, 0);
    apb(1'b0, OFS_STATUS, 0);
    chk(rd[19], 0);
    for (int s = 0; s < 4; s++)
    begin
      sel = 2'(s);
      apb(1'b1, OFS_SOURCE, {26'h0, sel, sel, sel});
      for (int k = 0; k < 4; k++)
      begin
        @(posedge pclk);
        coast_pin_n <= k[1];
        qstop_pin_n <= k[0];
        dcbrake_pin_n <= ~k[1];
        i_serial_master_model.send({5'h0, 1'b1, 5'h0, k[1], k[0], ~k[0], 2'b00});
        repeat (4) @(posedge pclk);
        #1;
        chk(coast_req_n, merge(sel, k[1], k[0]));
        chk(qstop_req_n, merge(sel, k[0], k[1]));
        chk(dcbrake_req_n, merge(sel, ~k[1], ~k[0]));
      end
    end
    apb(1'b1, OFS_SOURCE, 32'h0000_0015);
    i_serial_master_model.send(16'h0000);
    repeat (4) @(posedge pclk);
    #1;
    chk({coast_req_n, qstop_req_n, dcbrake_req_n}, 3'b110);
    i_serial_master_model.send(16'h0400);
    apb(1'b0, OFS_STATUS, 0);
    chk(rd[18:0], 19'h0_0400);
    chk(station_addr != i_serial_master_model.own_station, 1);
    wrap_up();
  end
endmodule
